// ---- rtl/etcc_pkg.sv ----
/*
 * etcc_pkg: register offsets, field positions, reset values and carrier
 * types for the edge timed current control block.
 * assumes: included before every other design file of the block.
 */
package etcc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte addresses on the wishbone slave
    localparam logic [3:0] ETCC_ADDR_SOURCE_SETTING = 4'h0;
    localparam logic [3:0] ETCC_ADDR_CTRL_LOW = 4'h4;
    localparam logic [3:0] ETCC_ADDR_CTRL_HIGH = 4'h8;
    localparam logic [3:0] ETCC_ADDR_IRQ_STATUS = 4'hc;

    // reads of the interrupt mask sit past the status word
    localparam logic [4:0] ETCC_ADDR_IRQ_MASK = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // source setting word: range in 9:8, trim in 7:2
    localparam int ETCC_RANGE_LSB = 8;
    localparam int ETCC_TRIM_LSB = 2;
    localparam logic [1:0] ETCC_RANGE_LOWEST = 2'h0;
    localparam logic [5:0] ETCC_TRIM_NEUTRAL = 6'h00;
    localparam logic [5:0] ETCC_TRIM_MAX_DOWN = 6'h20;
    localparam logic [5:0] ETCC_TRIM_MAX_UP = 6'h1f;

    // low control byte
    localparam int ETCC_CHAN2_POL_BIT = 7;
    localparam int ETCC_CHAN2_SEL_LSB = 5;
    localparam int ETCC_CHAN1_POL_BIT = 4;
    localparam int ETCC_CHAN1_SEL_LSB = 2;
    localparam int ETCC_CHAN2_HIT_BIT = 1;
    localparam int ETCC_CHAN1_HIT_BIT = 0;

    // high control byte
    localparam int ETCC_UNIT_ON_BIT = 7;
    localparam int ETCC_GATE_ON_BIT = 3;
    localparam int ETCC_ORDER_EN_BIT = 2;

    // interrupt status/mask bit
    localparam int ETCC_IRQ_DONE_BIT = 0;

    localparam logic [7:0] ETCC_BYTE_RESET = 8'h00;
    localparam int ETCC_SYNC_STAGES = 3;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic       polarity;
        logic [1:0] source_sel;
    } etcc_chan_cfg_t;

    typedef struct packed {
        logic unit_on;
        logic channel_gate_on;
        logic order_filter_en;
    } etcc_mode_t;

endpackage

// ---- rtl/etcc_sync.sv ----
/*
 * etcc_sync: three-stage synchroniser for one asynchronous level; the
 * output changes only when stages two and three agree.
 * assumes: ref_clk domain, synchronous active-high reset.
 */
module etcc_sync
    import etcc_pkg::*;
(
    // clock and control
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    // level
    input wire logic async_in,
    output logic sync_out
);

    logic [ETCC_SYNC_STAGES-1:0] stage_q;
    logic [ETCC_SYNC_STAGES-1:0] stage_d;
    logic out_q;
    logic out_d;

    always_comb begin
        stage_d = {stage_q[ETCC_SYNC_STAGES-2:0], async_in};
        out_d = out_q;
        // stage 0 feeds only stage 1
        if (stage_q[1] == stage_q[2]) begin
            out_d = stage_q[2];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stage_q <= '0;
            out_q <= 1'b0;
        end else if (clk_en) begin
            stage_q <= stage_d;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;

endmodule

// ---- rtl/etcc_edge_chan.sv ----
/*
 * etcc_edge_chan: one edge channel; picks one of four sources and turns
 * the present level into an event level according to polarity.
 * assumes: sources already in the ref_clk domain.
 */
module etcc_edge_chan
    import etcc_pkg::*;
(
    // configuration
    input wire etcc_chan_cfg_t cfg,
    // the four candidate sources
    input wire logic [3:0] sources,
    // result
    output logic event_lvl
);

    logic picked;

    always_comb begin
        picked = sources[cfg.source_sel];
        // level compare, no transition detect; polarity 0 means low is the event
        event_lvl = cfg.polarity ? picked : ~picked;
    end

endmodule

// ---- rtl/etcc_top.sv ----
/*
 * etcc_top: digital control of the charge time unit: two level-sensitive
 * edge channels, status bits, current source gate and its interrupt.
 * assumes: classic wishbone master on ref_clk, pins asynchronous,
 * event triggers synchronous to ref_clk.
 */
// What this block does
// (R01) Two-bit range field selects one of three ranges; zero is lowest.
// (R02) Six-bit signed trim: zero neutral, 100000 most down, 011111 most up.
// (R03) Each channel picks its source by a two-bit field, bits 3:2 and 6:5.
// (R04) Channels react to the present level, not to transitions.
// (R05) Polarity bits: bit 7 channel two, bit 4 channel one.
// (R06) With order filter on, channel two counts only after channel one.
// (R07) Status bits 1:0 set by hardware on a channel event.
// (R08) Config change matching present level sets the status bit at once.
// (R09) Current source on only while exactly one status bit is set.
// (R10) Software clears both status bits together before the next measurement.
// (R11) Software may write status bits to set or clear them.
// (R12) Interrupt flag set when current source turns off; masked request.
// (R13) Both channels blocked unless the gate-on bit 3 is set.
// (R14) Unit-on bit 7 of high byte; clearing it disables the unit.
// (R15) Polarity bit clear means negative, high-to-low response.
// (R16) Reset zeroes all control and status; source off, channels blocked.
module etcc_top
    import etcc_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // edge sources
    input wire logic ext_trigger_pin_a,
    input wire logic ext_trigger_pin_b,
    input wire logic [1:0] special_trigger,
    // analog control
    output logic current_src_en,
    output logic [1:0] current_range_sel,
    output logic [5:0] current_trim,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [1:0] range_q, range_d;
    logic [5:0] trim_q, trim_d;
    etcc_chan_cfg_t chan1_cfg_q, chan1_cfg_d;
    etcc_chan_cfg_t chan2_cfg_q, chan2_cfg_d;
    etcc_mode_t mode_q, mode_d;
    logic chan1_hit_q, chan1_hit_d;
    logic chan2_hit_q, chan2_hit_d;
    logic irq_stat_q, irq_stat_d;
    logic irq_mask_q, irq_mask_d;
    logic src_en_q, src_en_d;
    logic irq_q, irq_d;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;

    ////////////////////////////////////////////////////////////////////////
    // edge sources: pins through synchronisers, triggers used directly
    logic pin_a_s;
    logic pin_b_s;
    logic [3:0] sources;
    logic chan1_evt;
    logic chan2_evt;

    etcc_sync u_sync_a (
        .ref_clk(ref_clk),
        .srst(srst),
        .clk_en(clk_en),
        .async_in(ext_trigger_pin_a),
        .sync_out(pin_a_s)
    );

    etcc_sync u_sync_b (
        .ref_clk(ref_clk),
        .srst(srst),
        .clk_en(clk_en),
        .async_in(ext_trigger_pin_b),
        .sync_out(pin_b_s)
    );

    assign sources = {special_trigger[1], special_trigger[0], pin_b_s, pin_a_s};

    // source mux and polarity per channel
    etcc_edge_chan u_chan1 (
        .cfg(chan1_cfg_q), // R03 R05 R15
        .sources(sources),
        .event_lvl(chan1_evt) // R04
    );

    etcc_edge_chan u_chan2 (
        .cfg(chan2_cfg_q), // R03 R05 R15
        .sources(sources),
        .event_lvl(chan2_evt) // R04
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic bus_req;
    logic wr_src, wr_low, wr_high, wr_stat, wr_mask;
    logic [31:0] read_mux;

    always_comb begin
        bus_req = wb_cyc_i && wb_stb_i && !ack_q;
        wr_src = bus_req && wb_we_i && wb_adr_i == {1'b0, ETCC_ADDR_SOURCE_SETTING};
        wr_low = bus_req && wb_we_i && wb_sel_i[0]
            && wb_adr_i == {1'b0, ETCC_ADDR_CTRL_LOW};
        wr_high = bus_req && wb_we_i && wb_sel_i[0]
            && wb_adr_i == {1'b0, ETCC_ADDR_CTRL_HIGH};
        wr_stat = bus_req && wb_we_i && wb_sel_i[0]
            && wb_adr_i == {1'b0, ETCC_ADDR_IRQ_STATUS};
        wr_mask = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ETCC_ADDR_IRQ_MASK;
        read_mux = 32'h0000_0000;
        case (wb_adr_i)
            {1'b0, ETCC_ADDR_SOURCE_SETTING}: begin
                read_mux[ETCC_RANGE_LSB +: 2] = range_q;
                read_mux[ETCC_TRIM_LSB +: 6] = trim_q;
            end
            {1'b0, ETCC_ADDR_CTRL_LOW}: begin
                read_mux[ETCC_CHAN2_POL_BIT] = chan2_cfg_q.polarity;
                read_mux[ETCC_CHAN2_SEL_LSB +: 2] = chan2_cfg_q.source_sel;
                read_mux[ETCC_CHAN1_POL_BIT] = chan1_cfg_q.polarity;
                read_mux[ETCC_CHAN1_SEL_LSB +: 2] = chan1_cfg_q.source_sel;
                read_mux[ETCC_CHAN2_HIT_BIT] = chan2_hit_q;
                read_mux[ETCC_CHAN1_HIT_BIT] = chan1_hit_q;
            end
            {1'b0, ETCC_ADDR_CTRL_HIGH}: begin
                read_mux[ETCC_UNIT_ON_BIT] = mode_q.unit_on;
                read_mux[ETCC_GATE_ON_BIT] = mode_q.channel_gate_on;
                read_mux[ETCC_ORDER_EN_BIT] = mode_q.order_filter_en;
            end
            {1'b0, ETCC_ADDR_IRQ_STATUS}: begin
                read_mux[ETCC_IRQ_DONE_BIT] = irq_stat_q;
            end
            ETCC_ADDR_IRQ_MASK: begin
                read_mux[ETCC_IRQ_DONE_BIT] = irq_mask_q;
            end
            // unmapped addresses read zero and still acknowledge
            default: begin
                read_mux = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    logic gates_open;
    logic hw_set1, hw_set2;
    logic [7:0] wlow;

    always_comb begin
        range_d = range_q;
        trim_d = trim_q;
        chan1_cfg_d = chan1_cfg_q;
        chan2_cfg_d = chan2_cfg_q;
        mode_d = mode_q;
        irq_mask_d = irq_mask_q;
        wlow = wb_dat_i[7:0];
        ack_d = bus_req;
        rdata_d = bus_req ? read_mux : rdata_q;

        if (wr_src) begin
            if (wb_sel_i[1]) begin
                range_d = wb_dat_i[ETCC_RANGE_LSB +: 2]; // R01
            end
            if (wb_sel_i[0]) begin
                trim_d = wb_dat_i[ETCC_TRIM_LSB +: 6]; // R02
            end
        end
        if (wr_low) begin
            chan2_cfg_d.polarity = wlow[ETCC_CHAN2_POL_BIT]; // R05
            chan2_cfg_d.source_sel = wlow[ETCC_CHAN2_SEL_LSB +: 2]; // R03
            chan1_cfg_d.polarity = wlow[ETCC_CHAN1_POL_BIT]; // R05
            chan1_cfg_d.source_sel = wlow[ETCC_CHAN1_SEL_LSB +: 2]; // R03
        end
        if (wr_high) begin
            mode_d.unit_on = wb_dat_i[ETCC_UNIT_ON_BIT]; // R14
            mode_d.channel_gate_on = wb_dat_i[ETCC_GATE_ON_BIT]; // R13
            mode_d.order_filter_en = wb_dat_i[ETCC_ORDER_EN_BIT]; // R06
        end
        if (wr_mask) begin
            irq_mask_d = wb_dat_i[ETCC_IRQ_DONE_BIT];
        end

        // events are levels; a config that already matches sets the bit next cycle
        gates_open = mode_q.unit_on && mode_q.channel_gate_on; // R13 R14 R08
        hw_set1 = gates_open && chan1_evt; // R07
        hw_set2 = gates_open && chan2_evt && (!mode_q.order_filter_en || chan1_hit_q); // R06

        // software write first, hardware set wins over a clear
        chan1_hit_d = chan1_hit_q;
        chan2_hit_d = chan2_hit_q;
        if (wr_low) begin
            chan1_hit_d = wlow[ETCC_CHAN1_HIT_BIT]; // R11
            chan2_hit_d = wlow[ETCC_CHAN2_HIT_BIT]; // R11
        end
        if (hw_set1) begin
            chan1_hit_d = 1'b1; // R07
        end
        if (hw_set2) begin
            chan2_hit_d = 1'b1; // R07
        end

        // unit off keeps the current source dark whatever the status bits say
        src_en_d = mode_q.unit_on && (chan1_hit_q ^ chan2_hit_q); // R09 R14

        irq_stat_d = irq_stat_q;
        if (wr_stat && wb_dat_i[ETCC_IRQ_DONE_BIT]) begin
            irq_stat_d = 1'b0;
        end
        if (src_en_q && !src_en_d) begin
            irq_stat_d = 1'b1; // R12
        end
        irq_d = irq_stat_d && irq_mask_d; // R12
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            // R16
            range_q <= ETCC_RANGE_LOWEST;
            trim_q <= ETCC_TRIM_NEUTRAL;
            chan1_cfg_q <= '0;
            chan2_cfg_q <= '0;
            mode_q <= '0;
            chan1_hit_q <= 1'b0;
            chan2_hit_q <= 1'b0;
            irq_stat_q <= 1'b0;
            irq_mask_q <= 1'b0;
            src_en_q <= 1'b0;
            irq_q <= 1'b0;
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            range_q <= range_d;
            trim_q <= trim_d;
            chan1_cfg_q <= chan1_cfg_d;
            chan2_cfg_q <= chan2_cfg_d;
            mode_q <= mode_d;
            chan1_hit_q <= chan1_hit_d;
            chan2_hit_q <= chan2_hit_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            src_en_q <= src_en_d;
            irq_q <= irq_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flip-flops
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign current_src_en = src_en_q; // R09
    assign current_range_sel = range_q; // R01
    assign current_trim = trim_q; // R02
    assign irq = irq_q;

endmodule

// ---- bench/etcc_asserts.sv ----
/* etcc_asserts: port-level properties of etcc_top.
   assumes: bound to etcc_top, one clock; clk_en low freezes the block. */
module etcc_asserts
    import etcc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // analog control and interrupt
    input wire logic current_src_en,
    input wire logic [1:0] current_range_sel,
    input wire logic [5:0] current_trim,
    input wire logic irq
);
    logic mask_wr;
    logic mask_wr_q;
    default clocking cb @(posedge ref_clk);
    endclocking
    // a low clock enable stalls every answer, so checking pauses with it
    default disable iff (srst || !clk_en);
    assign mask_wr = wb_ack_o && wb_we_i && wb_adr_i == 5'h10;
    always_ff @(posedge ref_clk) begin
        mask_wr_q <= mask_wr;
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_wr(a);
        wb_ack_o && wb_we_i && wb_adr_i == a;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    property p_ack_answer;
        s_req |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    property p_reset;
        $fell(srst) |-> !current_src_en && !irq && current_range_sel == 2'h0
            && current_trim == 6'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared");
    property p_range;
        logic [1:0] r;
        (s_wr(5'h00) ##0 (wb_sel_i[1], r = wb_dat_i[9:8])) |=> current_range_sel == r;
    endproperty
    a_range: assert property (p_range) else $error("range not taken");
    property p_trim;
        logic [5:0] t;
        (s_wr(5'h00) ##0 (wb_sel_i[0], t = wb_dat_i[7:2])) |=> current_trim == t;
    endproperty
    a_trim: assert property (p_trim) else $error("trim not taken");
    property p_unit_off;
        s_wr(5'h08) ##0 (wb_sel_i[0] && !wb_dat_i[7]) |=> !current_src_en [*2];
    endproperty
    a_unit_off: assert property (p_unit_off) else $error("source on in disabled unit");
    property p_mask_off;
        s_wr(5'h10) ##0 (wb_sel_i[0] && !wb_dat_i[0]) |=> !irq [*2];
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked irq raised");
    property p_irq_cause;
        $rose(irq) |-> $fell(current_src_en) || mask_wr || mask_wr_q;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without source stop");
endmodule

// ---- bench/etcc_partner.sv ----
/* etcc_partner: the two edge pins and the two trigger sources.
   assumes: levels asked for by the bench; pins may lag one more cycle. */
module etcc_partner
    import etcc_pkg::*;
(
    // clock and requests: pin a, pin b, trigger 0, trigger 1
    input wire logic ref_clk,
    input wire logic [3:0] want,
    input wire logic slow,
    // sources
    output logic ext_trigger_pin_a,
    output logic ext_trigger_pin_b,
    output logic [1:0] special_trigger
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pin_d;
    initial {pin_d, ext_trigger_pin_b, ext_trigger_pin_a, special_trigger} = 6'h00;
    // triggers follow the clock; a slow pin shows the level a cycle late
    always @(posedge ref_clk) begin
        pin_d <= want[1:0];
        {ext_trigger_pin_b, ext_trigger_pin_a} <= slow ? pin_d : want[1:0];
        special_trigger <= want[3:2];
    end
endmodule

// ---- bench/edge_timed_current_control_bench.sv ----
/* edge_timed_current_control_bench: register, status, gate and irq checks.
   assumes: package, design, source model and checker compiled first. */
module edge_timed_current_control_bench
    import etcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [3:0] want = 4'h0;
    logic slow = 1'b0;
    logic pin_a;
    logic pin_b;
    logic [1:0] trig;
    logic src_en;
    logic [1:0] rng;
    logic [5:0] trim;
    logic irq;
    logic [31:0] seed = 32'hbe14d303;
    logic [31:0] lo;
    logic [5:0] t_exp;
    logic [1:0] r_exp;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;

    always #20 ref_clk = ~ref_clk;

    etcc_partner u_src (.ref_clk(ref_clk), .want(want), .slow(slow), .ext_trigger_pin_a(pin_a),
        .ext_trigger_pin_b(pin_b), .special_trigger(trig));
    etcc_top DUT (.ref_clk(ref_clk), .srst(srst), .clk_en(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ext_trigger_pin_a(pin_a), .ext_trigger_pin_b(pin_b),
        .special_trigger(trig), .current_src_en(src_en), .current_range_sel(rng),
        .current_trim(trim), .irq(irq));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [31:0] ctl_lo(input logic p2, input logic [1:0] s2,
        input logic p1, input logic [1:0] s1, input logic [1:0] h);
        return {24'h0, p2, s2, p1, s1, h};
    endfunction
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // classic cycle; stb is tied to cyc, the answer is awaited unbounded here
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] r);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= d;
        do @(posedge ref_clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk("read", e, r);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        for (int a = 0; a < 7; a++) rd(5'(a * 4), 32'h0);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            t_exp = (i == 0) ? ETCC_TRIM_NEUTRAL : (i == 1) ? ETCC_TRIM_MAX_DOWN
                : (i == 2) ? ETCC_TRIM_MAX_UP : seed[5:0];
            r_exp = (i == 0) ? ETCC_RANGE_LOWEST : (seed[9:8] == 2'h3) ? 2'h2 : seed[9:8];
            wr(5'h00, {22'h0, r_exp, t_exp, 2'h0});
            chk("range", 32'(r_exp), 32'(rng));
            chk("trim", 32'(t_exp), 32'(trim));
            rd(5'h00, {22'h0, r_exp, t_exp, 2'h0});
        end
        wr(5'h08, 32'h80);
        wr(5'h04, 32'h01);
        chk("src_en", 32'h1, 32'(src_en));
        wr(5'h04, 32'h03);
        chk("src_en", 32'h0, 32'(src_en));
        rd(5'h0c, 32'h1);
        chk("irq", 32'h0, 32'(irq));
        wr(5'h10, 32'h1);
        chk("irq", 32'h1, 32'(irq));
        wr(5'h0c, 32'h1);
        chk("irq", 32'h0, 32'(irq));
        wr(5'h04, 32'h00);
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                slow <= s[0];
                want <= (p[0] ? 4'h0 : 4'hf) ^ (4'h1 << s);
                lo = ctl_lo(!p[0], s[1:0], p[0], s[1:0], 2'h0);
                wr(5'h08, 32'h80);
                wr(5'h04, lo ^ 32'h10);
                wr(5'h08, 32'h88);
                repeat (8) @(posedge ref_clk);
                rd(5'h04, lo ^ 32'h10);
                wr(5'h04, lo);
                repeat (8) @(posedge ref_clk);
                rd(5'h04, lo | 32'h1);
                chk("src_en", 32'h1, 32'(src_en));
            end
        end
        wr(5'h08, 32'h80);
        wr(5'h04, lo);
        repeat (8) @(posedge ref_clk);
        rd(5'h04, lo);
        want <= 4'h2;
        lo = ctl_lo(1'b1, 2'h1, 1'b1, 2'h0, 2'h0);
        wr(5'h04, lo);
        wr(5'h08, 32'h8c);
        repeat (8) @(posedge ref_clk);
        rd(5'h04, lo);
        want <= 4'h3;
        repeat (8) @(posedge ref_clk);
        rd(5'h04, lo | 32'h3);
        chk("src_en", 32'h0, 32'(src_en));
        want <= 4'h2;
        wr(5'h08, 32'h80);
        wr(5'h04, lo);
        wr(5'h08, 32'h88);
        repeat (8) @(posedge ref_clk);
        rd(5'h04, lo | 32'h2);
        chk("src_en", 32'h1, 32'(src_en));
        wr(5'h08, 32'h00);
        chk("src_en", 32'h0, 32'(src_en));
        wr(5'h10, 32'h0);
        close_out();
    end
endmodule

bind etcc_top etcc_asserts u_chk (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .current_src_en(current_src_en), .current_range_sel(current_range_sel),
    .current_trim(current_trim), .irq(irq));
